// >>> inc/wdt_pkg.sv
// Constants and types shared by the watchdog block
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map (APB, one aligned word each)
  // ----------------------------------------------------------------
  localparam int         APB_AW    = 8;                       // Address width
  localparam logic [7:0] MODE_IDX  = 8'h0F;                   // Mode register index
  localparam logic [7:0] STAT_IDX  = 8'h10;                   // Status register index
  localparam logic [7:0] MODE_ADDR = {MODE_IDX[5:0], 2'b00};  // Byte address
  localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};  // Byte address

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int         MODE_W         = 8;      // Register width
  localparam int         TAP_LSB        = 0;      // Tap select low bit
  localparam int         TAP_MSB        = 1;      // Tap select high bit
  localparam int         HALT_BIT       = 2;      // Count during HALT
  localparam int         STOP_BIT       = 3;      // Count during STOP
  localparam logic [7:0] MODE_USED_MASK = 8'h0F;  // Upper nibble reserved
  localparam logic [7:0] MODE_RST_DEF   = 8'h0D;  // Default after reset

  // ----------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------
  localparam int ST_ENABLED = 0;  // Watchdog running
  localparam int ST_WINDOW  = 1;  // Mode write window open
  localparam int ST_LOCKED  = 2;  // Mode register locked
  localparam int ST_TIMEOUT = 3;  // Sticky: a timeout occurred

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;         // 20 MHz system clock
  localparam int POR_TIME_NS   = 2_500_000;  // Least reset hold time
  localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CRYSTAL_CLOCK   = 120;        // Write window in crystal clocks

  // ----------------------------------------------------------------
  // Counters and types
  // ----------------------------------------------------------------
  localparam int ONESHOT_W = 16;  // One-shot length width
  localparam int CNT_W     = 16;  // Watchdog tick counter width
  typedef logic [CNT_W-1:0]     tick_cnt_t;
  typedef logic [ONESHOT_W-1:0] os_len_t;
  localparam os_len_t   WINDOW_LEN  = os_len_t'(WINDOW_CRYSTAL_CLOCK);
  localparam os_len_t   POR_LEN_DEF = os_len_t'(POR_CYCLES);
  localparam os_len_t   OS_ONE      = 16'h0001;
  localparam tick_cnt_t TICK_ONE    = 16'h0001;
  localparam tick_cnt_t TAP0_DEF    = 16'h0100;  // Tap lengths in RC ticks
  localparam tick_cnt_t TAP1_DEF    = 16'h0200;
  localparam tick_cnt_t TAP2_DEF    = 16'h0400;
  localparam tick_cnt_t TAP3_DEF    = 16'h1000;

  // Flag values delivered to the core on a refresh
  localparam logic REFRESH_Z = 1'b0;
  localparam logic REFRESH_S = 1'b0;
  localparam logic REFRESH_V = 1'b0;

  // Watchdog state, Gray along off -> run -> hold
  typedef enum logic [1:0] {
    WD_OFF  = 2'b00,
    WD_RUN  = 2'b01,
    WD_HOLD = 2'b11
  } wd_state_t;

endpackage

// >>> inc/oneshot_if.sv
// Start, length and status wires of a one-shot timer
`timescale 1ns/1ps
interface oneshot_if
  import wdt_pkg::*;
();
  logic    start;   // Load length, one-cycle pulse
  os_len_t length;  // Cycles to run
  logic    busy;    // High while running
  logic    done;    // Last running cycle

  modport ctl (output start, output length, input busy, input done);
  modport tmr (input start, input length, output busy, output done);
endinterface

// >>> hw/bit_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module bit_sync
  import wdt_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;  // First stage, read only by sync_q
  logic sync_q;  // Second stage, safe to use

  // Only the second stage leaves this module
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// >>> hw/oneshot_timer.sv
// Loadable one-shot down counter
`timescale 1ns/1ps
module oneshot_timer
  import wdt_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  oneshot_if.tmr    os
);

  os_len_t left_q;  // Cycles still to run

  // A new start reloads even while running
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      left_q <= '0;
    else if (os.start)
      left_q <= os.length;
    else if (left_q != '0)
      left_q <= left_q - OS_ONE;
  end

  assign os.busy = (left_q != '0);
  assign os.done = (left_q == OS_ONE) && !os.start;

endmodule

// >>> hw/watchdog_unit.sv
// Watchdog timer with lockable mode register on APB
// ------------------------------------------------------------------
// Summary of operation
// (R1) Terminal count resets the processor core
// (R2) First refresh instruction starts the watchdog
// (R3) Later refreshes restart the full count
// (R4) Counter advances on RC oscillator ticks
// (R5) Refresh updates zero, sign, overflow flags
// (R6) Mode bits one and zero pick tap
// (R7) Mode bit two: count during HALT
// (R8) Mode bit three: count during STOP
// (R9) Mode bits seven to four reserved
// (R10) Writes accepted for 120 clocks after first instruction
// (R11) Locked register ignores writes until requalified
// (R12) Mode register reads back as zero
// (R13) Mode register decoded at index 0Fh
// (R14) Timeout fires the reset hold one-shot
// (R15) Tap lengths and defaults are parameters
// ------------------------------------------------------------------
`timescale 1ns/1ps
module watchdog_unit
  import wdt_pkg::*;
#(
  parameter tick_cnt_t   TAP0_TICKS = TAP0_DEF,      // Tap code 00
  parameter tick_cnt_t   TAP1_TICKS = TAP1_DEF,      // Tap code 01
  parameter tick_cnt_t   TAP2_TICKS = TAP2_DEF,      // Tap code 10
  parameter tick_cnt_t   TAP3_TICKS = TAP3_DEF,      // Tap code 11
  parameter logic [7:0]  MODE_RST   = MODE_RST_DEF,  // Mode after reset
  parameter os_len_t     POR_LEN    = POR_LEN_DEF    // Reset hold cycles
)
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              refresh_exec,
  input  wire logic              first_instr,
  input  wire logic              halt_mode,
  input  wire logic              stop_mode,
  input  wire logic              stop_recovery,
  input  wire logic              rc_osc,
  output logic                   core_reset,
  output logic                   flag_we,
  output logic                   flag_z,
  output logic                   flag_s,
  output logic                   flag_v
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wd_state_t  state_q;         // Watchdog state
  wd_state_t  state_d;         // Next state
  tick_cnt_t  count_q;         // RC ticks since start or refresh
  tick_cnt_t  tap_last;        // Last count before timeout
  logic [7:0] mode_q;          // Mode register, write only
  logic       armed_q;         // Waiting for first instruction
  logic       timeout_seen_q;  // Sticky timeout status
  logic       core_reset_q;    // Reset to the core
  logic       flag_we_q;       // Flag write strobe
  logic       flag_z_q;        // Zero flag value
  logic       flag_s_q;        // Sign flag value
  logic       flag_v_q;        // Overflow flag value
  logic [31:0] prdata_q;       // Read data, set in setup phase
  logic       rc_s;            // Synchronised oscillator level
  logic       rc_prev_q;       // Previous oscillator level
  logic       rc_tick;         // One tick per oscillator period
  logic       counting;        // Counter may advance now
  logic       timeout;         // Terminal count reached
  logic       window_open;     // Mode writes accepted
  logic       apb_setup;       // APB setup phase
  logic       apb_access;      // APB access phase
  logic       addr_hit;        // Address is mapped
  logic       wr_mode;         // Mode register write
  logic       wr_stat;         // Status register write
  logic [7:0] open_cnt_q;      // Window length monitor

  oneshot_if por_os ();  // Reset hold timer
  oneshot_if win_os ();  // Write window timer

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  // The RC oscillator is asynchronous, so only its synced level is used
  bit_sync u_rc_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (rc_osc),
    .sync_out (rc_s)
  );

  // Edge memory for the rising-edge tick
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rc_prev_q <= 1'b0;
    else
      rc_prev_q <= rc_s;
  end

  assign rc_tick = rc_s && !rc_prev_q;  // R4

  // ----------------------------------------------------------------
  // Count gating and tap select
  // ----------------------------------------------------------------
  // Sleep modes stall the count unless their mode bit allows it
  assign counting = rc_tick
                 && !(halt_mode && !mode_q[HALT_BIT])   // R7
                 && !(stop_mode && !mode_q[STOP_BIT]);  // R8

  // Tap lengths come from parameters since no figures are fixed
  always_comb
  begin
    unique case (mode_q[TAP_MSB:TAP_LSB])  // R6 R15
      2'b00: tap_last = TAP0_TICKS - TICK_ONE;
      2'b01: tap_last = TAP1_TICKS - TICK_ONE;
      2'b10: tap_last = TAP2_TICKS - TICK_ONE;
      2'b11: tap_last = TAP3_TICKS - TICK_ONE;
    endcase
  end

  // A refresh in the same cycle wins over the terminal count
  assign timeout = (state_q == WD_RUN) && counting && !refresh_exec
                && (count_q == tap_last);  // R1

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  // Next state; refresh is ignored while the core is held
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      WD_OFF:
        if (refresh_exec)
          state_d = WD_RUN;  // R2
      WD_RUN:
        if (timeout)
          state_d = WD_HOLD;  // R1
      WD_HOLD:
        if (por_os.done)
          state_d = WD_OFF;  // R14
      default:
        state_d = WD_OFF;  // Code 10 is illegal
    endcase
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      state_q <= WD_OFF;
    else
      state_q <= state_d;
  end

  // Core reset follows the hold state, from a flop
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      core_reset_q <= 1'b0;
    else
      core_reset_q <= (state_d == WD_HOLD);  // R1 R14
  end

  // ----------------------------------------------------------------
  // Tick counter
  // ----------------------------------------------------------------
  // Cleared outside RUN and on every refresh
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      count_q <= '0;
    else if (state_q != WD_RUN || refresh_exec)
      count_q <= '0;  // R3
    else if (counting)
      count_q <= count_q + TICK_ONE;  // R4
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  assign por_os.start  = timeout;  // R14
  assign por_os.length = POR_LEN;

  oneshot_timer u_por_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .os      (por_os)
  );

  // Window opens at the first instruction after a qualifying event
  assign win_os.start  = armed_q && first_instr;  // R10
  assign win_os.length = WINDOW_LEN;
  assign window_open   = win_os.busy;

  oneshot_timer u_win_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .os      (win_os)
  );

  // Reset, watchdog reset end and stop recovery re-arm the window
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      armed_q <= 1'b1;
    else if (por_os.done || stop_recovery)
      armed_q <= 1'b1;  // R11
    else if (first_instr)
      armed_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_hit   = (paddr == MODE_ADDR) || (paddr == STAT_ADDR);
  assign wr_mode    = apb_access && pwrite && (paddr == MODE_ADDR) && pstrb[0];  // R13
  assign wr_stat    = apb_access && pwrite && (paddr == STAT_ADDR) && pstrb[0];

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = apb_access && !addr_hit;
  assign prdata  = prdata_q;

  // Read data is captured in setup so it comes from a flop
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      prdata_q <= '0;
    else if (apb_setup && !pwrite)
    begin
      prdata_q <= '0;  // R12
      if (paddr == STAT_ADDR)
      begin
        prdata_q[ST_ENABLED] <= (state_q == WD_RUN);
        prdata_q[ST_WINDOW]  <= window_open;
        prdata_q[ST_LOCKED]  <= !window_open;
        prdata_q[ST_TIMEOUT] <= timeout_seen_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // A watchdog reset restores defaults; a locked write is dropped
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      mode_q <= MODE_RST & MODE_USED_MASK;
    else if (timeout)
      mode_q <= MODE_RST & MODE_USED_MASK;
    else if (wr_mode && window_open)  // R10 R11
      mode_q <= pwdata[MODE_W-1:0] & MODE_USED_MASK;  // R9
  end

  // Sticky timeout cause; a new timeout beats a clear
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      timeout_seen_q <= 1'b0;
    else if (timeout)
      timeout_seen_q <= 1'b1;
    else if (wr_stat && pwdata[ST_TIMEOUT])
      timeout_seen_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Core flags
  // ----------------------------------------------------------------
  // One strobe per executed refresh, none while held in reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      flag_we_q <= 1'b0;
      flag_z_q  <= 1'b0;
      flag_s_q  <= 1'b0;
      flag_v_q  <= 1'b0;
    end
    else
    begin
      flag_we_q <= refresh_exec && (state_q != WD_HOLD);  // R5
      if (refresh_exec && (state_q != WD_HOLD))
      begin
        flag_z_q <= REFRESH_Z;
        flag_s_q <= REFRESH_S;
        flag_v_q <= REFRESH_V;
      end
    end
  end

  assign core_reset = core_reset_q;
  assign flag_we    = flag_we_q;
  assign flag_z     = flag_z_q;
  assign flag_s     = flag_s_q;
  assign flag_v     = flag_v_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Counts cycles the window has been open since its start
  always_ff @(posedge clock)
  begin
    if (sys_rst || win_os.start)
      open_cnt_q <= '0;
    else if (window_open)
      open_cnt_q <= open_cnt_q + 8'h01;
  end

  terminal_reset_a: assert property (timeout |=> core_reset [*8])  // R1
    else $error("core reset not held after timeout");
  first_enable_a: assert property (  // R2
    (state_q == WD_OFF) && refresh_exec |=> (state_q == WD_RUN) && (count_q == '0))
    else $error("first refresh did not start watchdog");
  refresh_restart_a: assert property (  // R3
    (state_q == WD_RUN) && refresh_exec |=> (count_q == '0) && !core_reset)
    else $error("refresh did not restart count");
  rc_tick_a: assert property (  // R4
    (state_q == WD_RUN) && !rc_tick && !refresh_exec |=> $stable(count_q))
    else $error("count moved without oscillator tick");
  refresh_flags_a: assert property (  // R5
    refresh_exec && !core_reset |=> flag_we && (flag_z == REFRESH_Z))
    else $error("refresh did not update flags");
  tap_select_a: assert property (  // R6
    timeout |-> (count_q + TICK_ONE) == (mode_q[TAP_MSB]
                ? (mode_q[TAP_LSB] ? TAP3_TICKS : TAP2_TICKS)
                : (mode_q[TAP_LSB] ? TAP1_TICKS : TAP0_TICKS)))
    else $error("timeout at wrong tap");
  halt_gate_a: assert property (  // R7
    (state_q == WD_RUN) && halt_mode && !mode_q[HALT_BIT] && !refresh_exec
    |=> $stable(count_q))
    else $error("count moved in HALT");
  stop_gate_a: assert property (  // R8
    (state_q == WD_RUN) && stop_mode && !mode_q[STOP_BIT] && !refresh_exec
    |=> $stable(count_q))
    else $error("count moved in STOP");
  reserved_bits_a: assert property ((mode_q & ~MODE_USED_MASK) == 8'h00)  // R9
    else $error("reserved mode bits set");
  window_length_a: assert property ($fell(window_open) |-> open_cnt_q == WINDOW_LEN[7:0])  // R10
    else $error("write window wrong length");
  locked_ignore_a: assert property (  // R11
    wr_mode && !window_open && !timeout |=> $stable(mode_q))
    else $error("locked mode register changed");
  mode_read_a: assert property (  // R12
    apb_setup && !pwrite && (paddr == MODE_ADDR) |=> prdata == 32'h0000_0000)
    else $error("mode register readable");
  mode_decode_a: assert property (  // R13
    wr_mode && window_open && !timeout
    |=> mode_q == ($past(pwdata[7:0]) & MODE_USED_MASK))
    else $error("mode write not stored");
  hold_release_a: assert property ($fell(core_reset) |-> $past(por_os.done))  // R14
    else $error("core reset released early");

endmodule

// >>> verification/watchdog_timer_with_locked_mode_reg_bench.sv
// Self-checking bench for the watchdog block and its lockable mode register
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
  end

module watchdog_timer_with_locked_mode_reg_bench
  import wdt_pkg::*;
;
  // ----------------------------------------------------------------
  // Shortened counts, so a timeout takes tens of clocks, not thousands
  // ----------------------------------------------------------------
  localparam int TICK = 6;   // Clocks per oscillator tick
  localparam int T0   = 4;   // Ticks for tap code 00
  localparam int T1   = 8;   // Ticks for tap code 01
  localparam int POR  = 16;  // Reset hold length

  typedef struct {
    int          kind;  // 0 bus access, 1 flag update, 2 reset pulse
    logic [31:0] val;   // Expected value
    logic [31:0] mask;  // Bits that matter
    logic        err;   // Expected error response
  } note_t;

  logic              clock;          // System clock
  logic              sys_rst;        // Synchronous reset
  logic [APB_AW-1:0] paddr;          // Bus address
  logic              psel;           // Bus select
  logic              penable;        // Bus access phase
  logic              pwrite;         // Bus direction
  logic [31:0]       pwdata;         // Bus write data
  logic [3:0]        pstrb;          // Bus byte strobes
  logic [31:0]       prdata;         // Bus read data
  logic              pready;         // Bus ready
  logic              pslverr;        // Bus error
  logic              refresh_exec;   // Refresh instruction pulse
  logic              first_instr;    // Instruction executed pulse
  logic              halt_mode;      // Core halted
  logic              stop_mode;      // Device stopped
  logic              stop_recovery;  // Stop recovery pulse
  logic              rc_osc;         // Free-running oscillator
  logic              core_reset;     // Reset to the core
  logic              flag_we;        // Flag update strobe
  logic              flag_z;         // Zero flag
  logic              flag_s;         // Sign flag
  logic              flag_v;         // Overflow flag
  int                fails;          // Mismatches seen
  int                comparisons;    // Comparisons made
  int                rst_len;        // Length of current reset pulse
  int                rc_cnt;         // Oscillator divider
  note_t             notes[$];       // Expected results, oldest first

  watchdog_unit #(
    .TAP0_TICKS (tick_cnt_t'(T0)),
    .TAP1_TICKS (tick_cnt_t'(T1)),
    .TAP2_TICKS (tick_cnt_t'(10)),
    .TAP3_TICKS (tick_cnt_t'(12)),
    .MODE_RST   (MODE_RST_DEF),
    .POR_LEN    (os_len_t'(POR))
  ) uut (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .paddr         (paddr),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pwdata        (pwdata),
    .pstrb         (pstrb),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .refresh_exec  (refresh_exec),
    .first_instr   (first_instr),
    .halt_mode     (halt_mode),
    .stop_mode     (stop_mode),
    .stop_recovery (stop_recovery),
    .rc_osc        (rc_osc),
    .core_reset    (core_reset),
    .flag_we       (flag_we),
    .flag_z        (flag_z),
    .flag_s        (flag_s),
    .flag_v        (flag_v)
  );

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  // System clock, 20 MHz
  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  // Oscillator runs free, three clocks high and three low
  always @(posedge clock)
  begin
    if (rc_cnt == 2)
    begin
      rc_cnt <= 0;
      rc_osc <= ~rc_osc;
    end
    else
      rc_cnt <= rc_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Notes and checking
  // ----------------------------------------------------------------
  task automatic note(input int k, input logic [31:0] v, input logic [31:0] m, input logic e);
    notes.push_back('{k, v, m, e});
  endtask

  // Oldest note must match the result that just appeared
  task automatic take(input int k, input logic [31:0] got, input logic e);
    note_t n;
    if (notes.size() == 0)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", "unplanned_result", k, got);
    end
    else
    begin
      n = notes.pop_front();
      `CHK("result_kind", n.kind, k)
      `CHK("result_value", n.val, got & n.mask)
      `CHK("result_error", n.err, e)
    end
  endtask

  // Watches the outputs; values seen here are those before the edge
  always @(posedge clock)
  begin
    if (psel && penable && pready)
      take(0, prdata, pslverr);
    if (flag_we)
      take(1, {29'h0, flag_z, flag_s, flag_v}, 1'b0);
    if (core_reset)
      rst_len++;
    else if (rst_len != 0)
    begin
      take(2, 32'(rst_len), 1'b0);
      rst_len = 0;
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // One bus transfer; the request stands until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic ee);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    note(0, e, w ? 32'h0 : m, ee);
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Refresh instruction; every accepted one updates the flags
  task automatic refresh();
    @(posedge clock);
    refresh_exec <= 1'b1;
    note(1, {29'h0, REFRESH_Z, REFRESH_S, REFRESH_V}, 32'h7, 1'b0);
    @(posedge clock);
    refresh_exec <= 1'b0;
  endtask

  // First instruction (sel=1) or stop recovery (sel=0) pulse
  task automatic pulse(input bit sel);
    @(posedge clock);
    if (sel)
      first_instr <= 1'b1;
    else
      stop_recovery <= 1'b1;
    @(posedge clock);
    first_instr   <= 1'b0;
    stop_recovery <= 1'b0;
  endtask

  // Core reset must stay low for n clocks
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clock);
      if (core_reset !== 1'b0)
        seen = 1'b1;
    end
    `CHK("core_reset_quiet", 1'b0, seen)
  endtask

  // Timeout of t ticks must follow, with tick phase and sync slack
  task automatic expect_timeout(input int t);
    int n;
    n = 0;
    while (core_reset !== 1'b1 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    `CHK("timeout_delay", 1'b1, (n >= (t - 1) * TICK) && (n <= t * TICK + 8))
    note(2, POR, 32'hFFFFFFFF, 1'b0);
    n = 0;
    while (core_reset !== 1'b0 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Verdict and hang guard
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (notes.size() != 0)
      fails++;
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs about 1000 clocks; a hang is cut off well after
  initial
  begin
    repeat (30000) @(posedge clock);
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock = 0;
    sys_rst = 1;
    rc_osc = 0;
    rc_cnt = 0;
    rst_len = 0;
    paddr = '0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    pwdata = '0;
    pstrb = 4'hF;
    refresh_exec = 0;
    first_instr = 0;
    halt_mode = 0;
    stop_mode = 0;
    stop_recovery = 0;
    fails = 0;
    comparisons = 0;
    void'($urandom(26541));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    // Off and window shut until the core runs
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h0, 32'h3, 1'b0);
    pulse(1'b1);
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h2, 32'h6, 1'b0);
    // Tap 0, no count in HALT or STOP; reserved nibble random
    apb(MODE_ADDR, 1'b1, {24'h0, 4'($urandom), 4'h0}, 32'h0, 32'h0, 1'b0);
    apb(MODE_ADDR, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(8'h80, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    repeat (120) @(posedge clock);
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h4, 32'h6, 1'b0);
    // Late write would pick tap 3; the tap-0 timing below shows it was ignored
    apb(MODE_ADDR, 1'b1, 32'h0000000F, 32'h0, 32'h0, 1'b0);
    quiet(60);
    refresh();
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h1, 32'h1, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      quiet(5 + $urandom % 10);
      refresh();
    end
    halt_mode <= 1'b1;
    quiet(120);
    halt_mode <= 1'b0;
    refresh();
    expect_timeout(T0);
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h8, 32'h9, 1'b0);
    apb(STAT_ADDR, 1'b1, 32'h8, 32'h0, 32'h0, 1'b0);
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h0, 32'h8, 1'b0);
    // After a timeout the watchdog waits for a new first refresh
    quiet(80);
    pulse(1'b1);
    apb(MODE_ADDR, 1'b1, {24'h0, 4'($urandom), 4'h4}, 32'h0, 32'h0, 1'b0);
    refresh();
    halt_mode <= 1'b1;
    expect_timeout(T0);
    halt_mode <= 1'b0;
    // Lock, then re-open through stop recovery
    pulse(1'b1);
    apb(MODE_ADDR, 1'b1, 32'h00000009, 32'h0, 32'h0, 1'b0);
    repeat (125) @(posedge clock);
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h4, 32'h6, 1'b0);
    pulse(1'b0);
    pulse(1'b1);
    apb(STAT_ADDR, 1'b0, 32'h0, 32'h2, 32'h6, 1'b0);
    apb(MODE_ADDR, 1'b1, 32'h00000001, 32'h0, 32'h0, 1'b0);
    refresh();
    stop_mode <= 1'b1;
    quiet(120);
    stop_mode <= 1'b0;
    refresh();
    expect_timeout(T1);
    repeat (5) @(posedge clock);
    wrap_up();
  end
endmodule
